// >>> rtl/rcs_pkg.sv
// Constants and types for the radio configuration and data port
// Function
// RQ1: Configuration kept in 8-bit registers, 7-bit address.
// RQ2: Each transfer is one 16-bit frame.
// RQ3: Host sends address top bit first.
// RQ4: Direction bit high writes, low reads.
// RQ5: Host holds select low through frame.
// RQ6: Serial input sampled on config clock rise.
// RQ7: Host changes input bit on falling edge.
// RQ8: Byte stored after last data bit arrives.
// RQ9: Registers survive programmed power-down.
// RQ10: Read data driven out on falling edges.
// RQ11: Host captures read bits on rising edges.
// RQ12: Host raises select between frames.
// RQ13: Serial pins undriven while select inactive.
// RQ14: Two-bit format field selects data format.
// RQ15: NRZ transmit: sample data at clock rise.
// RQ16: Receive: recovered clock and data, host samples rising.
// RQ17: Manchester transmit: device encodes host NRZ bits.
// RQ18: Zero low-to-high, one high-to-low.
// RQ19: Manchester receive: decoded NRZ plus clock out.
// RQ20: Bit clock runs continuously unless gated.
// RQ21: Split cleared: data pin bidirectional by mode.
// RQ22: Split set: receive data on lock pin; code does so only in NRZ or Manchester receive.
// RQ23: Lock pin low when locked, else status.
// RQ24: Partial write frame discarded, registers unchanged.
package rcs_pkg;
   // Clock and baud timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BAUD_HZ = 38_400;
   localparam int BAUD_HALF_CYC = CLK_HZ / (2 * BAUD_HZ);
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] NRZ_PER = CNT_W'(2 * BAUD_HALF_CYC);
   localparam logic [CNT_W-1:0] MAN_PER = CNT_W'(4 * BAUD_HALF_CYC);
   // Serial frame layout
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int REG_NUM = 128;
   localparam int BITCNT_W = 5;
   localparam logic [BITCNT_W-1:0] CNT_ADDR_DONE = 5'h07;
   localparam logic [BITCNT_W-1:0] CNT_FRAME_DONE = 5'h0F;
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;
   // Register addresses and field positions
   localparam logic [ADDR_W-1:0] ADDR_MAIN = 7'h00;
   localparam logic [ADDR_W-1:0] ADDR_IFACE = 7'h01;
   localparam logic [ADDR_W-1:0] ADDR_MODULATION_CTRL_REG = 7'h02;
   localparam int MAIN_TX_BIT = 0;
   localparam int MAIN_PD_BIT = 1;
   localparam int IFACE_SPLIT_BIT = 0;
   localparam int IFACE_GATE_CS_BIT = 1;
   localparam int IFACE_GATE_LOCK_BIT = 2;
   localparam int IFACE_LOCKSEL_LSB = 3;
   localparam int MODULATION_CTRL_REG_FMT_LSB = 0;
   // Transmit buffer
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_W = 1;
   // Data formats, lock pin functions, serial states
   typedef enum logic [1:0] {
      RCS_FMT_NRZ, RCS_FMT_MAN, RCS_FMT_ASYNC, RCS_FMT_RSV
   } rcs_fmt_e;
   typedef enum logic [1:0] {
      RCS_LK_PLL, RCS_LK_CS, RCS_LK_HIGH, RCS_LK_LOW
   } rcs_locksel_e;
   typedef enum logic [1:0] {
      RCS_SPI_IDLE, RCS_SPI_HEAD, RCS_SPI_DATA, RCS_SPI_DONE
   } rcs_spi_e;
endpackage : rcs_pkg

// >>> rtl/rcs_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module rcs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Asynchronous inputs and synchronised outputs
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : rcs_sync

// >>> rtl/rcs_fifo.sv
// Parameterised valid/ready FIFO for the transmit bit path
`timescale 1ns/1ps
module rcs_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // Honest full and empty from the fill count
   assign in_ready = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg];

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
         end
         if (pop) begin
            rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
         end
         count_reg <= (AW+1)'(count_reg + push - pop);
      end
   end
endmodule : rcs_fifo

// >>> rtl/rcs_radio_port.sv
// Radio configuration serial port and synchronous data port
`timescale 1ns/1ps
module rcs_radio_port import rcs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Configuration serial pins
   input wire logic cfg_clk_in,
   input wire logic cfg_sel_n,
   input wire logic cfg_serial_in,
   output logic cfg_serial_out,
   output logic cfg_serial_out_oe,
   // Data port pins
   input wire logic data_io_in,
   output logic data_io_out,
   output logic data_io_oe,
   output logic bit_clock_pin,
   output logic lock_pin,
   // Radio core status
   input wire logic pll_locked,
   input wire logic carrier_sense,
   input wire logic rx_demod_bit,
   // Modulator side
   output logic mod_valid,
   input wire logic mod_ready,
   output logic mod_chip,
   // Mode outputs
   output logic tx_mode,
   output logic power_down
);
   logic [3:0] sync_q;
   logic sclk_s, sel_s, sdi_s, dio_s;
   logic sclk_q_reg;
   logic rise_ev, fall_ev;
   rcs_spi_e state_reg;
   logic [BITCNT_W-1:0] bit_cnt_reg;
   logic [ADDR_W-1:0] shift_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic dir_reg;
   logic [DATA_W-1:0] rd_shift_reg;
   logic sdo_reg;
   logic wr_pulse;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] regs [REG_NUM];
   logic [DATA_W-1:0] iface_r, modulation_ctrl_reg_r, main_r;
   rcs_fmt_e fmt;
   rcs_locksel_e locksel;
   logic split, sync_mode;
   logic [CNT_W-1:0] per, half, samp_pt, cnt_reg;
   logic run;
   logic bclk_reg;
   logic rx_prev_reg, rx_edge;
   logic rx_hold_reg, rx_data_reg;
   logic tx_push, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [FIFO_W-1:0] fifo_out_data;
   logic chip_reg, have_reg, half_reg;
   logic lock_reg;

   // Format decode, used by several concerns
   function automatic logic fmt_sync(input rcs_fmt_e f);
      return (f == RCS_FMT_NRZ) || (f == RCS_FMT_MAN);
   endfunction : fmt_sync

   // Pins from the host pass two flops; select idles high
   rcs_sync #(.W(4), .RST_VAL(4'h4)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({cfg_clk_in, cfg_sel_n, cfg_serial_in, data_io_in}),
      .q(sync_q)
   );
   assign {sclk_s, sel_s, sdi_s, dio_s} = sync_q;

   // Edge finder on the synchronised configuration clock
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sclk_q_reg <= 1'b0;
      end else begin
         sclk_q_reg <= sclk_s;
      end
   end
   assign rise_ev = sclk_s && !sclk_q_reg; // RQ6
   assign fall_ev = !sclk_s && sclk_q_reg;

   // Frame sequencer: address, direction, then data
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg <= RCS_SPI_IDLE;
         bit_cnt_reg <= '0;
         shift_reg <= '0;
         addr_reg <= '0;
         dir_reg <= 1'b0;
      end else if (sel_s) begin
         state_reg <= RCS_SPI_IDLE; // RQ24
         bit_cnt_reg <= '0;
      end else begin
         case (state_reg)
            RCS_SPI_IDLE: begin
               state_reg <= RCS_SPI_HEAD;
            end
            RCS_SPI_HEAD: begin
               if (rise_ev) begin
                  shift_reg <= {shift_reg[ADDR_W-2:0], sdi_s}; // RQ3
                  bit_cnt_reg <= BITCNT_W'(bit_cnt_reg + 1'b1);
                  if (bit_cnt_reg == CNT_ADDR_DONE) begin
                     addr_reg <= shift_reg; // RQ1
                     dir_reg <= sdi_s; // RQ4
                     state_reg <= RCS_SPI_DATA;
                  end
               end
            end
            RCS_SPI_DATA: begin
               if (rise_ev) begin
                  shift_reg <= {shift_reg[ADDR_W-2:0], sdi_s};
                  bit_cnt_reg <= BITCNT_W'(bit_cnt_reg + 1'b1);
                  if (bit_cnt_reg == CNT_FRAME_DONE) begin
                     state_reg <= RCS_SPI_DONE; // RQ2
                  end
               end
            end
            RCS_SPI_DONE: begin
               state_reg <= RCS_SPI_DONE;
            end
            default: begin
               state_reg <= RCS_SPI_IDLE;
            end
         endcase
      end
   end

   // Commit only on the last data bit of a whole write frame
   assign wr_pulse = !sel_s && rise_ev && dir_reg &&
      (state_reg == RCS_SPI_DATA) && (bit_cnt_reg == CNT_FRAME_DONE);
   assign wr_data = {shift_reg, sdi_s};

   // Register store; power-down bit leaves contents alone
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < REG_NUM; i++) begin
            regs[i] <= REG_RST;
         end
      end else if (wr_pulse) begin
         regs[addr_reg] <= wr_data; // RQ8 RQ9
      end
   end

   // Read-back shifter, bits change on falling clock edges
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_shift_reg <= '0;
         sdo_reg <= 1'b0;
      end else if (state_reg == RCS_SPI_HEAD && rise_ev &&
                   bit_cnt_reg == CNT_ADDR_DONE) begin
         rd_shift_reg <= regs[shift_reg]; // RQ10
      end else if (state_reg == RCS_SPI_DATA && fall_ev && !dir_reg) begin
         sdo_reg <= rd_shift_reg[DATA_W-1]; // RQ10
         rd_shift_reg <= {rd_shift_reg[DATA_W-2:0], 1'b0};
      end
   end
   assign cfg_serial_out = sdo_reg;
   // Drive only during the data half of a read frame
   assign cfg_serial_out_oe = !dir_reg && // RQ13
      (state_reg == RCS_SPI_DATA || state_reg == RCS_SPI_DONE);

   // Control fields
   assign main_r = regs[ADDR_MAIN];
   assign iface_r = regs[ADDR_IFACE];
   assign modulation_ctrl_reg_r = regs[ADDR_MODULATION_CTRL_REG];
   assign fmt = rcs_fmt_e'(modulation_ctrl_reg_r[MODULATION_CTRL_REG_FMT_LSB +: 2]); // RQ14
   assign locksel = rcs_locksel_e'(iface_r[IFACE_LOCKSEL_LSB +: 2]);
   assign split = iface_r[IFACE_SPLIT_BIT];
   assign sync_mode = fmt_sync(fmt);
   assign tx_mode = main_r[MAIN_TX_BIT];
   assign power_down = main_r[MAIN_PD_BIT];

   // Bit period: a Manchester bit spans two symbols
   assign per = (fmt == RCS_FMT_MAN) ? MAN_PER : NRZ_PER;
   assign half = per >> 1;
   assign samp_pt = (fmt == RCS_FMT_MAN) ? (per >> 2) : half;
   // Gating by carrier sense, lock and a full transmit buffer
   assign run = sync_mode && !power_down && // RQ20
      !(iface_r[IFACE_GATE_CS_BIT] && !carrier_sense) &&
      !(iface_r[IFACE_GATE_LOCK_BIT] && !pll_locked) &&
      !(tx_mode && !fifo_in_ready);
   assign rx_edge = rx_demod_bit ^ rx_prev_reg;

   // Bit phase counter, realigned to NRZ receive transitions
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_reg <= '0;
      end else if (!run) begin
         cnt_reg <= cnt_reg;
      end else if (!tx_mode && fmt == RCS_FMT_NRZ && rx_edge) begin
         cnt_reg <= '0; // RQ16
      end else if (cnt_reg >= CNT_W'(per - 1'b1)) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= CNT_W'(cnt_reg + 1'b1);
      end
   end

   // Bit clock pin: high in the second half of each bit
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bclk_reg <= 1'b0;
      end else begin
         bclk_reg <= sync_mode && (cnt_reg >= half); // RQ20
      end
   end
   assign bit_clock_pin = bclk_reg;

   // Receive sampling, decode and presentation at the falling edge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_prev_reg <= 1'b0;
         rx_hold_reg <= 1'b0;
         rx_data_reg <= 1'b0;
      end else begin
         rx_prev_reg <= rx_demod_bit;
         if (!sync_mode) begin
            rx_data_reg <= rx_demod_bit;
         end else if (run && cnt_reg == samp_pt) begin
            rx_hold_reg <= rx_demod_bit; // RQ19
         end else if (run && cnt_reg >= CNT_W'(per - 1'b1)) begin
            rx_data_reg <= rx_hold_reg; // RQ16
         end
      end
   end

   // Host transmit bit taken on the same clock edge on which the clock pin rises
   assign tx_push = run && tx_mode && (cnt_reg == half); // RQ15 RQ17

   rcs_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_txbuf (
      .clk(clk),
      .rstn(rstn),
      .in_valid(tx_push),
      .in_ready(fifo_in_ready),
      .in_data(dio_s),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );
   assign fifo_out_ready = !have_reg;

   // Modulator feed: NRZ as is, Manchester as chip pairs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         chip_reg <= 1'b0;
         have_reg <= 1'b0;
         half_reg <= 1'b0;
      end else if (!have_reg) begin
         if (fifo_out_valid) begin
            chip_reg <= fifo_out_data[0]; // RQ18
            have_reg <= 1'b1;
            half_reg <= 1'b0;
         end
      end else if (mod_ready) begin
         if (fmt == RCS_FMT_MAN && !half_reg) begin
            chip_reg <= !chip_reg; // RQ17 RQ18
            half_reg <= 1'b1;
         end else begin
            have_reg <= 1'b0;
         end
      end
   end
   assign mod_valid = have_reg;
   assign mod_chip = chip_reg;

   // Data pin direction follows the mode when split is cleared
   assign data_io_oe = !tx_mode && !power_down && !split; // RQ21
   assign data_io_out = rx_data_reg;

   // Lock pin: receive data when split in NRZ or Manchester receive, else selected status
   always_ff @(posedge clk) begin
      if (!rstn) begin
         lock_reg <= 1'b1;
      end else if (split && sync_mode && !tx_mode) begin
         lock_reg <= rx_data_reg; // RQ22
      end else begin
         case (locksel)
            RCS_LK_PLL: lock_reg <= !pll_locked; // RQ23
            RCS_LK_CS: lock_reg <= !carrier_sense;
            RCS_LK_HIGH: lock_reg <= 1'b1;
            default: lock_reg <= 1'b0;
         endcase
      end
   end
   assign lock_pin = lock_reg;

   // Checks on the logic above
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_frame_length: assert property ( // RQ2
      wr_pulse |-> $past(state_reg, 2) != RCS_SPI_IDLE
         && bit_cnt_reg == CNT_FRAME_DONE)
      else $error("write outside sixteenth bit");
   chk_write_commit: assert property ( // RQ8
      wr_pulse |=> regs[$past(addr_reg)] == $past(wr_data))
      else $error("written byte not stored");
   chk_abort_nowrite: assert property ( // RQ24
      sel_s |-> !wr_pulse ##1 !wr_pulse)
      else $error("write after select released");
   chk_pins_release: assert property ( // RQ13
      sel_s |=> !cfg_serial_out_oe)
      else $error("output driven while deselected");
   chk_sdo_fall: assert property ( // RQ10
      $changed(cfg_serial_out) |-> $past(fall_ev))
      else $error("read bit changed off a falling edge");
   chk_dio_dir: assert property ( // RQ21
      tx_mode |-> !data_io_oe)
      else $error("data pin driven in transmit");
   chk_lock_route: assert property ( // RQ22
      (split && sync_mode && !tx_mode) |=> lock_pin == $past(rx_data_reg))
      else $error("receive data missing on lock pin");
   chk_lock_level: assert property ( // RQ23
      (!split && locksel == RCS_LK_PLL) |=> lock_pin == !$past(pll_locked))
      else $error("lock pin level wrong");
   chk_manch_pair: assert property ( // RQ18
      (mod_valid && mod_ready && fmt == RCS_FMT_MAN && !half_reg)
         |=> mod_valid && mod_chip == !$past(mod_chip))
      else $error("Manchester second chip not inverted");
   chk_tx_rise: assert property ( // RQ15
      tx_push |-> fifo_in_ready ##1 $rose(bit_clock_pin))
      else $error("transmit sample not tied to clock rise");
   chk_gate_hold: assert property ( // RQ20
      (!run && !$past(run)) |=> $stable(bit_clock_pin))
      else $error("bit clock moved while gated");

   cov_write: cover property (wr_pulse);
   cov_read: cover property (cfg_serial_out_oe && fall_ev);
   cov_manch: cover property (mod_valid && half_reg);
   cov_split: cover property (split && sync_mode && !tx_mode && run);
endmodule : rcs_radio_port

// >>> test/rcs_host_model.sv
// Host model: configuration serial master and data pin partner
`timescale 1ns/1ps
module rcs_host_model (
   // Clock
   input wire logic clk,
   // Configuration serial pins
   output logic cfg_clk_in,
   output logic cfg_sel_n,
   output logic cfg_serial_in,
   input wire logic cfg_serial_out,
   input wire logic cfg_serial_out_oe,
   // Data port pins
   input wire logic data_io_out,
   input wire logic data_io_oe,
   output logic data_io_in,
   input wire logic bit_clock_pin,
   input wire logic lock_pin
);
   logic sdo_last = 1'b0;
   logic tx_bit = 1'b0;
   logic oe_seen = 1'b0;
   bit cap_on = 1'b0;
   bit cap_lock = 1'b0;
   logic q_rx[$];
   logic q_tx[$];
   // Released read line shows the inverse of its last driven value
   wire sdo_wire = cfg_serial_out_oe ? cfg_serial_out : ~sdo_last;
   // Shared data pin level from both drivers
   assign data_io_in = data_io_oe ? data_io_out : tx_bit;
   // Serial lines idle with select high and clock still
   initial begin
      cfg_clk_in = 1'b0;
      cfg_sel_n = 1'b1;
      cfg_serial_in = 1'b0;
   end
   // Remember what the device last drove on the read line
   always @(posedge clk) begin
      if (cfg_serial_out_oe === 1'b1) sdo_last <= cfg_serial_out;
   end
   // Next transmit bit goes out on the falling bit clock edge
   always @(negedge bit_clock_pin) begin
      #1;
      tx_bit = q_tx.size() > 0 ? q_tx.pop_front() : 1'b0;
   end
   // Received data captured on the rising bit clock edge
   always @(posedge bit_clock_pin) begin
      if (cap_on) q_rx.push_back(cap_lock ? lock_pin : data_io_in);
   end
   // Wait whole clock cycles, then step just past the edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk
   // One frame; fewer than 16 bits makes an aborted frame
   task automatic frame(input logic [6:0] addr, input logic wr,
                        input logic [7:0] wd, input int nbits,
                        output logic [7:0] rd);
      logic [15:0] word;
      word = {addr, wr, wd};
      rd = 8'h00;
      wait_clk(1);
      cfg_sel_n = 1'b0;
      wait_clk(4);
      for (int i = 15; i >= 16 - nbits; i--) begin
         cfg_serial_in = word[i];
         wait_clk(4);
         if (i < 8) rd = {rd[6:0], sdo_wire};
         cfg_clk_in = 1'b1;
         wait_clk(4);
         cfg_clk_in = 1'b0;
      end
      oe_seen = cfg_serial_out_oe;
      wait_clk(5);
      cfg_sel_n = 1'b1;
      cfg_serial_in = ~cfg_serial_in;
      wait_clk(5);
   endtask : frame
endmodule : rcs_host_model

// >>> test/tb_top.sv
// Self-checking testbench for the radio configuration and data port
`timescale 1ns/1ps
module tb_top;
   import rcs_pkg::*;
   localparam logic [7:0] PAT = 8'hB2;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic pll_locked, carrier_sense, rx_demod_bit, mod_ready;
   logic cfg_clk_in, cfg_sel_n, cfg_serial_in, cfg_serial_out;
   logic cfg_serial_out_oe, data_io_in, data_io_out, data_io_oe;
   logic bit_clock_pin, lock_pin, mod_valid, mod_chip;
   logic tx_mode, power_down;
   logic q_chip[$];
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   // Design and host partner
   rcs_radio_port dut (.clk(clk), .rstn(rstn), .cfg_clk_in(cfg_clk_in),
      .cfg_sel_n(cfg_sel_n), .cfg_serial_in(cfg_serial_in),
      .cfg_serial_out(cfg_serial_out),
      .cfg_serial_out_oe(cfg_serial_out_oe), .data_io_in(data_io_in),
      .data_io_out(data_io_out), .data_io_oe(data_io_oe),
      .bit_clock_pin(bit_clock_pin), .lock_pin(lock_pin),
      .pll_locked(pll_locked), .carrier_sense(carrier_sense),
      .rx_demod_bit(rx_demod_bit), .mod_valid(mod_valid),
      .mod_ready(mod_ready), .mod_chip(mod_chip), .tx_mode(tx_mode),
      .power_down(power_down));
   rcs_host_model host (.clk(clk), .cfg_clk_in(cfg_clk_in),
      .cfg_sel_n(cfg_sel_n), .cfg_serial_in(cfg_serial_in),
      .cfg_serial_out(cfg_serial_out),
      .cfg_serial_out_oe(cfg_serial_out_oe), .data_io_out(data_io_out),
      .data_io_oe(data_io_oe), .data_io_in(data_io_in),
      .bit_clock_pin(bit_clock_pin), .lock_pin(lock_pin));
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   // Modulator side: collect every accepted chip
   always @(posedge clk) begin
      if (mod_valid === 1'b1 && mod_ready === 1'b1) q_chip.push_back(mod_chip);
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 99000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.frame(a, 1'b1, d, 16, r);
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      host.frame(a, 1'b0, 8'h00, 16, d);
   endtask : rd
   // Count bit clock changes over n cycles
   task automatic cnt_edges(input int n, output int e);
      logic prev;
      e = 0;
      prev = bit_clock_pin;
      repeat (n) begin
         host.wait_clk(1);
         if (bit_clock_pin !== prev) e++;
         prev = bit_clock_pin;
      end
   endtask : cnt_edges
   // Find the marker one, then compare the pattern that follows it
   task automatic cmp_stream(input string name, input logic q[$],
                             input bit man);
      int i;
      int s;
      logic [7:0] got;
      logic [7:0] inv;
      i = 0;
      while (i + 1 < q.size() && !(q[i] === 1'b1 &&
             (!man || q[i+1] === 1'b1))) i++;
      s = man ? i + 3 : i + 1;
      for (int k = 0; k < 8; k++) begin
         got = {got[6:0], q[s + k * (man ? 2 : 1)]};
         inv = {inv[6:0], ~q[s + 2 * k + 1]};
      end
      check(name, got, PAT);
      if (man) check({name, " second chip"}, inv, PAT);
   endtask : cmp_stream
   task automatic t_reset();
      check("lock_pin", lock_pin, 8'h01);
      check("mod_valid", mod_valid, 8'h00);
      check("tx_mode", tx_mode, 8'h00);
      check("power_down", power_down, 8'h00);
      check("read oe", cfg_serial_out_oe, 8'h00);
      check("data_io_oe", data_io_oe, 8'h01);
      host.wait_clk(3);
      $display("done reset");
   endtask : t_reset
   task automatic t_regs();
      logic [6:0] a[3] = '{7'h05, 7'h7F, 7'h2A};
      logic [7:0] d[3] = '{8'hA5, 8'h5A, 8'h81};
      logic [7:0] r;
      for (int k = 0; k < 3; k++) wr(a[k], d[k]);
      for (int k = 0; k < 3; k++) begin
         rd(a[k], r);
         check("read back", r, d[k]);
         check("oe in read", host.oe_seen, 8'h01);
         check("oe after read", cfg_serial_out_oe, 8'h00);
      end
      host.frame(7'h05, 1'b1, 8'h3C, 15, r);
      rd(7'h05, r);
      check("after abort", r, 8'hA5);
      wr(ADDR_MAIN, 8'h02);
      check("power_down", power_down, 8'h01);
      rd(7'h05, r);
      check("kept in power down", r, 8'hA5);
      wr(ADDR_MAIN, 8'h00);
      $display("done registers");
   endtask : t_regs
   task automatic t_lock_gate();
      logic [3:0] exp = 4'b0110;
      int e;
      pll_locked = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_IFACE, {3'b000, 2'(i), 3'b000});
         host.wait_clk(5);
         check("lock_pin select", lock_pin, exp[i]);
      end
      wr(ADDR_IFACE, 8'h02);
      cnt_edges(1400, e);
      check("gated by carrier", 8'(e), 8'h00);
      carrier_sense = 1'b1;
      cnt_edges(1400, e);
      check("running clock", 8'(e > 0), 8'h01);
      wr(ADDR_IFACE, 8'h04);
      pll_locked = 1'b0;
      host.wait_clk(2);
      cnt_edges(1400, e);
      check("gated by lock", 8'(e), 8'h00);
      pll_locked = 1'b1;
      wr(ADDR_IFACE, 8'h00);
      wr(ADDR_MODULATION_CTRL_REG, 8'h02);
      cnt_edges(1400, e);
      check("async clock edges", 8'(e), 8'h00);
      check("async clock level", bit_clock_pin, 8'h00);
      $display("done lock and gating");
   endtask : t_lock_gate
   // Receive: two zeros, a marker one, then the pattern
   task automatic t_rx(input logic [7:0] iface, input bit man);
      logic [10:0] seq;
      seq = {3'b001, PAT};
      wr(ADDR_MODULATION_CTRL_REG, {7'h00, man});
      wr(ADDR_IFACE, iface);
      check("data_io_oe rx", data_io_oe, {7'h00, ~iface[0]});
      host.q_rx.delete();
      host.cap_lock = iface[0];
      host.cap_on = 1'b1;
      for (int k = 10; k >= 0; k--) begin
         @(negedge bit_clock_pin);
         #1;
         rx_demod_bit = seq[k];
         if (man) begin
            @(posedge bit_clock_pin);
            #1;
            rx_demod_bit = ~seq[k];
         end
      end
      @(negedge bit_clock_pin);
      #1;
      rx_demod_bit = 1'b0;
      host.wait_clk(2800);
      host.cap_on = 1'b0;
      cmp_stream("rx data", host.q_rx, 1'b0);
      $display("done receive");
   endtask : t_rx
   // NRZ transmit with the modulator stalled until the buffer refuses, then Manchester transmit
   task automatic t_tx();
      int e;
      wr(ADDR_IFACE, 8'h00);
      wr(ADDR_MODULATION_CTRL_REG, 8'h00);
      q_chip.delete();
      wr(ADDR_MAIN, 8'h01);
      check("data_io_oe tx", data_io_oe, 8'h00);
      host.q_tx = '{1'b0, 1'b0, 1'b1};
      for (int k = 7; k >= 0; k--) host.q_tx.push_back(PAT[k]);
      host.wait_clk(24000);
      cnt_edges(1400, e);
      check("full buffer stall", 8'(e), 8'h00);
      mod_ready = 1'b1;
      host.wait_clk(2000);
      cmp_stream("nrz chips", q_chip, 1'b0);
      wr(ADDR_MAIN, 8'h00);
      wr(ADDR_MODULATION_CTRL_REG, 8'h01);
      q_chip.delete();
      wr(ADDR_MAIN, 8'h01);
      host.q_tx = '{1'b0, 1'b1};
      for (int k = 7; k >= 0; k--) host.q_tx.push_back(PAT[k]);
      host.wait_clk(15000);
      cmp_stream("manchester chips", q_chip, 1'b1);
      $display("done transmit");
   endtask : t_tx
   // Reset, then the scenarios in turn
   initial begin
      pll_locked = 1'b0;
      carrier_sense = 1'b0;
      rx_demod_bit = 1'b0;
      mod_ready = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_reset();
      t_regs();
      t_lock_gate();
      t_rx(8'h00, 1'b0);
      t_rx(8'h01, 1'b0);
      t_rx(8'h00, 1'b1);
      t_tx();
      finish_test();
   end
endmodule : tb_top
